// ### common/asc_pkg.sv
// Constants, types and helpers shared by the async space timing block
// Operation
// RULE1 - Four chip-select spaces each own an independent configuration register.
// RULE2 - Accesses started after a configuration write use the new settings.
// RULE3 - Bit 31 picks normal mode (0) or select strobe mode (1).
// RULE4 - Bit 30 set enables extended wait cycles for the space.
// RULE5 - Software keeps extended wait off for spaces run as NAND flash.
// RULE6 - Software keeps extended wait off when no wait pin exists.
// RULE7 - With extended wait on, both strobe widths must be nonzero.
// RULE8 - Write setup lasts bits 29-26 plus one cycles.
// RULE9 - Write strobe lasts bits 25-20 plus one cycles.
// RULE10 - Write hold lasts bits 19-17 plus one cycles.
// RULE11 - Read setup lasts bits 16-13 plus one cycles.
// RULE12 - Read strobe lasts bits 12-7 plus one cycles.
// RULE13 - Read hold lasts bits 6-4 plus one cycles.
// RULE14 - At least turnaround field plus one cycles between accesses.
// RULE15 - No turnaround for same direction in the same space.
// RULE16 - Bits 1-0 pick 8-bit (0) or 16-bit (1) bus; 2,3 reserved.
// RULE17 - Reset gives maximum timings, normal mode, wait off, 8-bit bus.
// RULE18 - Raw bit 2 sets on a rising edge of the wait input.
// RULE19 - Raw bit 0 sets when extended wait exceeds the maximum count.
// RULE20 - Raw bits set regardless of the event enables.
// RULE21 - Writing 1 clears a raw bit and its masked copy; 0 does nothing.
// RULE22 - Raw bits 31-3 and 1 read zero; software writes them zero.
// RULE23 - Extended wait ends after at most (max count plus one) times 16 cycles.
// RULE24 - Wait polarity chooses low (0) or high (1) as waiting; resets to 1.
// RULE25 - Masked bit sets only for enabled events and pulses the interrupt line.
// RULE26 - Phases run setup, strobe, hold with address and select held stable.
package asc_pkg;

  localparam logic [7:0] OFS_WAIT_CFG = 8'h04;
  localparam logic [7:0] OFS_CFG0 = 8'h10;
  localparam logic [7:0] OFS_RAW = 8'h40;
  localparam logic [7:0] OFS_MASKED = 8'h44;
  localparam logic [7:0] OFS_EN_SET = 8'h48;
  localparam logic [7:0] OFS_EN_CLR = 8'h4c;

  localparam int POS_WPOL = 28;
  localparam int POS_EV_TIMEOUT = 0;
  localparam int POS_EV_RISE = 2;

  localparam logic [31:0] CFG_RESET = 32'h3ffffffc;
  localparam logic WPOL_RESET = 1'b1;
  localparam logic [7:0] MAX_WAIT_COUNT_RESET = 8'h80;
  localparam logic [1:0] BW_16 = 2'h1;
  localparam logic [12:0] WAIT_UNIT_CYCLES = 13'h10;
  localparam logic [2:0] GAP_MAX = 3'h4;

  typedef struct packed {
    logic ss;
    logic ew;
    logic [3:0] wsu;
    logic [5:0] wst;
    logic [2:0] whd;
    logic [3:0] rsu;
    logic [5:0] rst;
    logic [2:0] rhd;
    logic [1:0] ta;
    logic [1:0] bw;
  } asc_cfg_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_TURN = 5'b00010,
    S_SETUP = 5'b00100,
    S_STROBE = 5'b01000,
    S_HOLD = 5'b10000
  } asc_state_t;

  // Field value of the given phase; the phase lasts this plus one cycles, plus any extended wait in strobe
  function automatic logic [5:0] asc_ph_fld(asc_cfg_t c, logic wr, asc_state_t s);
    logic [5:0] v;
    v = 6'h00;
    if (s == S_SETUP)
      v = wr ? {2'h0, c.wsu} : {2'h0, c.rsu};
    else if (s == S_STROBE)
      v = wr ? c.wst : c.rst;
    else if (s == S_HOLD)
      v = wr ? {3'h0, c.whd} : {3'h0, c.rhd};
    return v;
  endfunction

  function automatic logic [2:0] asc_ta3(logic [1:0] ta);
    return {1'b0, ta};
  endfunction

endpackage

// ### common/asc_cfg_if.sv
// Link between the access controller and the configuration bank
`timescale 1ns/1ps
interface asc_cfg_if;
  import asc_pkg::*;
  logic wr;
  logic [1:0] wr_idx;
  asc_cfg_t wr_data;
  logic [1:0] rd_idx;
  asc_cfg_t rd_data;
  logic [1:0] acc_idx;
  asc_cfg_t acc_cfg;
  modport ctl (output wr, wr_idx, wr_data, rd_idx, acc_idx, input rd_data, acc_cfg);
  modport bank (input wr, wr_idx, wr_data, rd_idx, acc_idx, output rd_data, acc_cfg);
endinterface

// ### design/asc_cfg_bank.sv
// Four per-space configuration registers with two read ports
`timescale 1ns/1ps
module asc_cfg_bank
  import asc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  asc_cfg_if.bank cif
);

  asc_cfg_t cfg [4];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < 4; i++)
        cfg[i] <= asc_cfg_t'(CFG_RESET); // RULE17
    end
    else if (cif.wr)
      cfg[cif.wr_idx] <= cif.wr_data; // RULE1
  end

  // Reads are combinational so register reads still answer in one cycle
  assign cif.rd_data = cfg[cif.rd_idx];
  assign cif.acc_cfg = cfg[cif.acc_idx];

  a_cfg_reset_val: assert property (@(posedge i_ref_clk) // RULE17
    i_sys_rst |=> (cfg[0] == CFG_RESET && cfg[3] == CFG_RESET))
    else $error("config register not at reset value");

  a_cfg_write_own: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE1
    cif.wr |=> cfg[$past(cif.wr_idx)] == $past(cif.wr_data))
    else $error("config write not stored in its own space");

endmodule

// ### design/asc_top.sv
// Async memory space sequencer with per-space timing and raw event flags
`timescale 1ns/1ps
module asc_top
  import asc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_acc_req,
  input wire logic i_acc_write,
  input wire logic [1:0] i_acc_space,
  input wire logic [15:0] i_acc_addr,
  input wire logic [15:0] i_acc_wdata,
  output logic o_acc_busy,
  output logic o_acc_done,
  output logic [15:0] o_acc_rdata,
  output logic [3:0] o_em_cs_n,
  output logic o_em_we_n,
  output logic o_em_oe_n,
  output logic [15:0] o_em_addr,
  output logic [15:0] o_em_dout,
  output logic o_em_doe,
  output logic o_em_wide,
  input wire logic [15:0] i_em_din,
  input wire logic i_external_wait_input,
  output logic o_event_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  asc_cfg_if cif ();

  asc_state_t st_q;
  asc_state_t next_st;
  asc_cfg_t cur;
  asc_cfg_t cfg_now;
  logic cur_wr;
  logic [1:0] cur_sp;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic [5:0] cnt_q;
  logic [12:0] wcnt_q;
  logic [12:0] wlim;
  logic [2:0] gap_q;
  logic have_last;
  logic [1:0] last_sp;
  logic last_wr;
  logic turn_need;
  logic turn_q;
  logic wait_hold;
  logic to_ev;
  logic wait_s1;
  logic wait_s2;
  logic wait_s3;
  logic wait_act;
  logic rise_ev;
  logic [15:0] din_s1;
  logic [15:0] din_s2;
  logic wait_polarity;
  logic [7:0] max_wait_count;
  logic [1:0] raw_q;
  logic [1:0] msk_q;
  logic [1:0] en_q;
  logic [1:0] ev;
  logic [1:0] clr;
  logic take;
  logic active;
  logic cs_on;
  logic [12:0] ph_len;

  // Bit 0 of the pair is the timeout event, bit 1 the wait rise event
  function automatic logic [31:0] ev_pack(logic [1:0] v);
    logic [31:0] w;
    w = 32'h0;
    w[POS_EV_TIMEOUT] = v[0];
    w[POS_EV_RISE] = v[1];
    return w;
  endfunction

  function automatic logic [1:0] ev_unpack(logic [31:0] w);
    return {w[POS_EV_RISE], w[POS_EV_TIMEOUT]};
  endfunction

  function automatic logic is_cfg(logic [7:0] a);
    return a[7:4] == OFS_CFG0[7:4] && a[1:0] == 2'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration bank

  asc_cfg_bank u_bank (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .cif (cif.bank)
  );

  assign cif.wr = i_reg_wr && is_cfg(i_reg_addr);
  assign cif.wr_idx = i_reg_addr[3:2];
  assign cif.wr_data = asc_cfg_t'(i_reg_wdata);
  assign cif.rd_idx = i_reg_addr[3:2];
  // Snapshot source: the requested space at take, else the running one
  assign cif.acc_idx = (st_q == S_IDLE) ? i_acc_space : cur_sp;

  ////////////////////////////////////////////////////////////////////////////
  // Wait configuration and pin synchronisers

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      wait_polarity <= WPOL_RESET; // RULE24
      max_wait_count <= MAX_WAIT_COUNT_RESET;
    end
    else if (i_reg_wr && i_reg_addr == OFS_WAIT_CFG)
    begin
      wait_polarity <= i_reg_wdata[POS_WPOL];
      max_wait_count <= i_reg_wdata[7:0];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      wait_s1 <= 1'b0;
      wait_s2 <= 1'b0;
      wait_s3 <= 1'b0;
      din_s1 <= 16'h0000;
      din_s2 <= 16'h0000;
    end
    else
    begin
      wait_s1 <= i_external_wait_input;
      wait_s2 <= wait_s1;
      wait_s3 <= wait_s2;
      din_s1 <= i_em_din;
      din_s2 <= din_s1;
    end
  end

  assign rise_ev = wait_s2 && !wait_s3; // RULE18
  assign wait_act = (wait_s2 == wait_polarity); // RULE24
  assign wlim = 13'({max_wait_count, 4'h0}) + WAIT_UNIT_CYCLES; // RULE23

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  assign take = (st_q == S_IDLE) && i_acc_req;
  assign cfg_now = (st_q == S_IDLE) ? cif.acc_cfg : cur; // RULE2
  assign turn_need = have_last && (last_sp != i_acc_space || last_wr != i_acc_write); // RULE15
  assign wait_hold = cur.ew && wait_act && (wcnt_q != wlim); // RULE4
  assign to_ev = (st_q == S_STROBE) && (cnt_q == 6'h00) && cur.ew && wait_act
    && (wcnt_q == wlim); // RULE19

  always_comb
  begin
    next_st = st_q;
    unique case (st_q)
      S_IDLE:
        if (i_acc_req)
          next_st = (turn_need && gap_q < asc_ta3(cif.acc_cfg.ta)) ? S_TURN : S_SETUP; // RULE14
      S_TURN:
        if (gap_q >= asc_ta3(cur.ta))
          next_st = S_SETUP; // RULE14
      S_SETUP:
        if (cnt_q == 6'h00)
          next_st = S_STROBE; // RULE26
      S_STROBE:
        if (cnt_q == 6'h00 && !wait_hold)
          next_st = S_HOLD; // RULE23
      S_HOLD:
        if (cnt_q == 6'h00)
          next_st = S_IDLE;
      default:
        next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      st_q <= S_IDLE;
    else
      st_q <= next_st;
  end

  // Snapshot at take keeps settings and address stable through the access
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      cur <= asc_cfg_t'(CFG_RESET);
      cur_wr <= 1'b0;
      cur_sp <= 2'h0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      turn_q <= 1'b0;
    end
    else if (take)
    begin
      cur <= cif.acc_cfg; // RULE1 RULE2
      cur_wr <= i_acc_write;
      cur_sp <= i_acc_space;
      addr_q <= i_acc_addr; // RULE26
      wdata_q <= i_acc_wdata;
      turn_q <= turn_need;
    end
  end

  // Phase counter loads the field and counts down to zero
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      cnt_q <= 6'h00;
    else if (st_q != S_SETUP && next_st == S_SETUP)
      cnt_q <= asc_ph_fld(cfg_now, take ? i_acc_write : cur_wr, S_SETUP); // RULE8 RULE11
    else if (st_q == S_SETUP && next_st == S_STROBE)
      cnt_q <= asc_ph_fld(cur, cur_wr, S_STROBE); // RULE9 RULE12
    else if (st_q == S_STROBE && next_st == S_HOLD)
      cnt_q <= asc_ph_fld(cur, cur_wr, S_HOLD); // RULE10 RULE13
    else if (cnt_q != 6'h00)
      cnt_q <= cnt_q - 6'h01;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || st_q != S_STROBE)
      wcnt_q <= 13'h0000;
    else if (cnt_q == 6'h00 && wait_hold)
      wcnt_q <= wcnt_q + 13'h0001; // RULE23
  end

  // Gap saturates; it only has to reach the largest turnaround
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      gap_q <= GAP_MAX;
      have_last <= 1'b0;
      last_sp <= 2'h0;
      last_wr <= 1'b0;
    end
    else if (st_q == S_HOLD)
    begin
      gap_q <= 3'h0; // RULE14
      have_last <= 1'b1;
      last_sp <= cur_sp;
      last_wr <= cur_wr;
    end
    else if (gap_q != GAP_MAX)
      gap_q <= gap_q + 3'h1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_acc_busy <= 1'b0;
      o_acc_done <= 1'b0;
      o_acc_rdata <= 16'h0000;
    end
    else
    begin
      o_acc_done <= (st_q == S_HOLD) && (next_st == S_IDLE);
      if (take)
        o_acc_busy <= 1'b1;
      else if (st_q == S_HOLD && next_st == S_IDLE)
        o_acc_busy <= 1'b0;
      if (st_q == S_STROBE && next_st == S_HOLD && !cur_wr)
        o_acc_rdata <= (cur.bw == BW_16) ? din_s2 : {8'h00, din_s2[7:0]}; // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory pins, one cycle behind the sequencer state

  assign active = (st_q == S_SETUP) || (st_q == S_STROBE) || (st_q == S_HOLD);
  assign cs_on = active && (!cur.ss || st_q == S_STROBE); // RULE3

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_em_cs_n <= 4'hf;
      o_em_we_n <= 1'b1;
      o_em_oe_n <= 1'b1;
      o_em_doe <= 1'b0;
      o_em_addr <= 16'h0000;
      o_em_dout <= 16'h0000;
      o_em_wide <= 1'b0;
    end
    else
    begin
      o_em_cs_n <= cs_on ? ~(4'h1 << cur_sp) : 4'hf; // RULE26
      o_em_we_n <= !(st_q == S_STROBE && cur_wr);
      o_em_oe_n <= !(st_q == S_STROBE && !cur_wr);
      o_em_doe <= active && cur_wr;
      o_em_addr <= addr_q;
      // Reserved widths fall back to the narrow bus
      o_em_dout <= (cur.bw == BW_16) ? wdata_q : {8'h00, wdata_q[7:0]}; // RULE16
      o_em_wide <= (cur.bw == BW_16);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags

  assign ev = {rise_ev, to_ev};
  assign clr = (i_reg_wr && (i_reg_addr == OFS_RAW || i_reg_addr == OFS_MASKED))
    ? ev_unpack(i_reg_wdata) : 2'h0;

  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      raw_q <= 2'h0;
      msk_q <= 2'h0;
      o_event_irq <= 1'b0;
    end
    else
    begin
      raw_q <= ev | (raw_q & ~clr); // RULE20 RULE21
      msk_q <= (ev & en_q) | (msk_q & ~clr); // RULE25 RULE21
      o_event_irq <= |(ev & en_q); // RULE25
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      en_q <= 2'h0;
    else if (i_reg_wr && i_reg_addr == OFS_EN_SET)
      en_q <= en_q | ev_unpack(i_reg_wdata);
    else if (i_reg_wr && i_reg_addr == OFS_EN_CLR)
      en_q <= en_q & ~ev_unpack(i_reg_wdata);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || !i_reg_rd)
      o_reg_rdata <= 32'h0;
    else if (is_cfg(i_reg_addr))
      o_reg_rdata <= 32'(cif.rd_data);
    else if (i_reg_addr == OFS_WAIT_CFG)
      o_reg_rdata <= {3'h0, wait_polarity, 20'h0, max_wait_count};
    else if (i_reg_addr == OFS_RAW)
      o_reg_rdata <= ev_pack(raw_q); // RULE22
    else if (i_reg_addr == OFS_MASKED)
      o_reg_rdata <= ev_pack(msk_q);
    else if (i_reg_addr == OFS_EN_SET || i_reg_addr == OFS_EN_CLR)
      o_reg_rdata <= ev_pack(en_q);
    else
      o_reg_rdata <= 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || st_q != next_st)
      ph_len <= 13'h0000;
    else
      ph_len <= ph_len + 13'h0001;
  end

  a_setup_width: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE8 RULE11
    (st_q == S_STROBE && $past(st_q) == S_SETUP)
      |-> $past(ph_len) == {7'h00, asc_ph_fld(cur, cur_wr, S_SETUP)})
    else $error("setup phase length wrong");

  a_strobe_width: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE9 RULE12
    (st_q == S_HOLD && $past(st_q) == S_STROBE && !cur.ew)
      |-> $past(ph_len) == {7'h00, asc_ph_fld(cur, cur_wr, S_STROBE)})
    else $error("strobe phase length wrong");

  a_hold_width: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE10 RULE13
    (st_q == S_IDLE && $past(st_q) == S_HOLD)
      |-> $past(ph_len) == {7'h00, asc_ph_fld(cur, cur_wr, S_HOLD)})
    else $error("hold phase length wrong");

  a_turn_gap_min: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE14
    (st_q == S_SETUP && $past(st_q) != S_SETUP && turn_q)
      |-> $past(gap_q) >= asc_ta3(cur.ta))
    else $error("turnaround gap too short");

  a_same_dir_skip: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE15
    (take && have_last && !turn_need) |=> st_q == S_SETUP)
    else $error("turnaround inserted for same direction");

  a_wait_bound: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE23
    st_q == S_STROBE |-> wcnt_q <= wlim)
    else $error("extended wait exceeded limit");

  a_timeout_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE19
    to_ev |=> raw_q[0] && st_q == S_HOLD)
    else $error("timeout not flagged");

  a_no_ext_wait: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE4
    (st_q == S_STROBE && cnt_q == 6'h00 && !cur.ew) |=> st_q == S_HOLD)
    else $error("wait inserted while disabled");

  a_rise_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE18
    rise_ev |=> raw_q[1])
    else $error("wait rise not flagged");

  a_raw_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE21
    (clr[0] && !ev[0]) |=> !raw_q[0] && !msk_q[0])
    else $error("write one did not clear flags");

  a_mask_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE25
    $rose(msk_q[1]) |-> $past(en_q[1]) && o_event_irq)
    else $error("masked flag set while disabled");

  a_rsv_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE22
    (i_reg_rd && i_reg_addr == OFS_RAW) |=> o_reg_rdata[31:3] == 29'h0 && !o_reg_rdata[1])
    else $error("reserved raw bits not zero");

  a_ss_cs_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RULE3
    (st_q == S_SETUP && cur.ss) |=> o_em_cs_n == 4'hf)
    else $error("select strobe mode asserted select in setup");

  c_read_access: cover property (@(posedge i_ref_clk) o_acc_done && !cur_wr);
  c_turn_used: cover property (@(posedge i_ref_clk) st_q == S_TURN);
  c_timeout: cover property (@(posedge i_ref_clk) to_ev);
  c_rise_masked: cover property (@(posedge i_ref_clk) rise_ev && en_q[1]);

endmodule

// ### testbench/asc_mem_model.sv
// Behavioural asynchronous memory standing on the external pins
`timescale 1ns/1ps
module asc_mem_model
(
  input wire logic [3:0] i_cs_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_din,
  input wire logic i_doe,
  output logic [15:0] o_dout
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  logic sel;
  initial last = 16'h0000;
  assign sel = ~&i_cs_n;
  ////////////////////////////////////////////////////////////////////////////
  // Stored while select and write strobe are low and the block drives data
  always @*
    if (sel && !i_we_n && i_doe)
      mem[i_addr[7:0]] = i_din;
  // Released bus shows the inverse of the last value, so stale data never passes
  always @*
    if (sel && !i_oe_n)
    begin
      o_dout = mem[i_addr[7:0]];
      last = mem[i_addr[7:0]];
    end
    else
      o_dout = ~last;
endmodule

// ### testbench/test_asc_top.sv
// Self-checking bench for the async space timing block
`timescale 1ns/1ps
module test_asc_top;
  import asc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] ra = 8'h00;
  logic [31:0] rwd = 32'h0;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic [31:0] rrdata;
  logic req = 1'b0;
  logic awr = 1'b0;
  logic [1:0] asp = 2'h0;
  logic [15:0] aad = 16'h0;
  logic [15:0] awd = 16'h0;
  logic busy, done, wide, doe, we_n, oe_n, irq, wd;
  logic [15:0] ardata, em_addr, em_dout, em_din;
  logic [3:0] cs_n;
  logic wt = 1'b0;
  int n_fail = 0;
  int n_checks = 0;
  int n_irq = 0;
  int su, st, hd, pre;
  asc_cfg_t cf [2];
  always #10 clk = ~clk;
  always @(posedge clk)
    if (irq === 1'b1)
      n_irq <= n_irq + 1;
  asc_top DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_reg_addr(ra), .i_reg_wdata(rwd),
    .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rrdata), .i_acc_req(req),
    .i_acc_write(awr), .i_acc_space(asp), .i_acc_addr(aad), .i_acc_wdata(awd),
    .o_acc_busy(busy), .o_acc_done(done), .o_acc_rdata(ardata), .o_em_cs_n(cs_n),
    .o_em_we_n(we_n), .o_em_oe_n(oe_n), .o_em_addr(em_addr), .o_em_dout(em_dout),
    .o_em_doe(doe), .o_em_wide(wide), .i_em_din(em_din),
    .i_external_wait_input(wt), .o_event_irq(irq));
  asc_mem_model u_mem (.i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(em_addr),
    .i_din(em_dout), .i_doe(doe), .o_dout(em_din));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    check(rrdata, exp);
  endtask
  // One access; counts pin cycles of setup, strobe, hold and the idle gap before it
  task automatic access(input logic w, input logic [1:0] s, input logic [15:0] d);
    logic on;
    su = 0;
    st = 0;
    hd = 0;
    pre = 0;
    @(posedge clk);
    req <= 1'b1;
    awr <= w;
    asp <= s;
    aad <= 16'h0012;
    awd <= d;
    // The pin cycle right after the previous done belongs to the gap as well
    #1;
    if (cs_n[s])
      pre++;
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge clk);
      if (i == 0)
        req <= 1'b0;
      #1;
      if (i == 0)
        check(busy, 1'b1);
      on = w ? !we_n : !oe_n;
      if (on)
      begin
        st++;
        wd = wide;
        check(em_addr, 16'h0012);
      end
      else if (!cs_n[s])
      begin
        if (st == 0)
          su++;
        else
          hd++;
      end
      else if (st == 0 && su == 0)
        pre++;
      if (done === 1'b1)
      begin
        check(busy, 1'b0);
        return;
      end
    end
    n_fail++;
    close_out();
  endtask
  task automatic chk_ph(input logic ss, input int a, input int b, input int c);
    check(su, ss ? 0 : a + 1);
    check(st, b + 1);
    check(hd, ss ? 0 : c + 1);
  endtask
  task automatic rise;
    @(posedge clk);
    wt <= 1'b0;
    repeat (4) @(posedge clk);
    wt <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cf[0] = '{1'b0, 1'b0, 4'h2, 6'h03, 3'h1, 4'h1, 6'h05, 3'h2, 2'h0, 2'h1};
    cf[1] = '{1'b1, 1'b0, 4'h0, 6'h00, 3'h0, 4'h3, 6'h06, 3'h7, 2'h3, 2'h0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      reg_chk(OFS_CFG0 + 8'(4 * i), CFG_RESET);
    reg_chk(OFS_RAW, 32'h0);
    reg_wr(8'h80, 32'hffffffff);
    reg_chk(8'h80, 32'h0);
    reg_wr(OFS_CFG0 + 8'h04, 32'hc0ffee01);
    reg_wr(OFS_CFG0 + 8'h08, 32'h0123458c);
    reg_chk(OFS_CFG0 + 8'h04, 32'hc0ffee01);
    reg_chk(OFS_CFG0 + 8'h08, 32'h0123458c);
    reg_chk(OFS_CFG0 + 8'h0c, CFG_RESET);
    $display("test registers done");
    // Same space rewritten between accesses; each access follows the new fields
    for (int k = 0; k < 2; k++)
    begin
      reg_wr(OFS_CFG0, cf[k]);
      reg_chk(OFS_CFG0, cf[k]);
      access(1'b1, 2'h0, 16'ha5c3);
      chk_ph(cf[k].ss, cf[k].wsu, cf[k].wst, cf[k].whd);
      access(1'b0, 2'h0, 16'h0000);
      chk_ph(cf[k].ss, cf[k].rsu, cf[k].rst, cf[k].rhd);
      check(ardata, cf[k].bw == BW_16 ? 16'ha5c3 : 16'h00c3);
      check(wd, cf[k].bw == BW_16);
    end
    $display("test phases done");
    access(1'b0, 2'h3, 16'h0000);
    access(1'b0, 2'h3, 16'h0000);
    chk_ph(1'b0, 15, 63, 7);
    check(pre < 4, 1'b1);
    access(1'b1, 2'h3, 16'h1234);
    check(pre >= 4, 1'b1);
    access(1'b1, 2'h2, 16'h1234);
    check(pre >= 4, 1'b1);
    $display("test turnaround done");
    rise();
    reg_chk(OFS_RAW, 32'h4);
    reg_chk(OFS_MASKED, 32'h0);
    check(n_irq, 0);
    reg_wr(OFS_RAW, 32'h0);
    reg_chk(OFS_RAW, 32'h4);
    reg_wr(OFS_RAW, 32'h4);
    reg_chk(OFS_RAW, 32'h0);
    reg_wr(OFS_EN_SET, 32'h4);
    rise();
    reg_chk(OFS_MASKED, 32'h4);
    reg_wr(OFS_RAW, 32'h4);
    reg_chk(OFS_MASKED, 32'h0);
    $display("test events done");
    // Strobe widths kept nonzero while extended wait is on
    reg_wr(OFS_CFG0 + 8'h04,
      asc_cfg_t'{1'b0, 1'b1, 4'h0, 6'h01, 3'h0, 4'h0, 6'h01, 3'h0, 2'h0, 2'h1});
    @(posedge clk);
    wt <= 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      reg_wr(OFS_WAIT_CFG, 32'(p) << POS_WPOL);
      @(posedge clk);
      wt <= p[0];
      repeat (5) @(posedge clk);
      access(1'b0, 2'h1, 16'h0000);
      check(st > 2 && st <= 18, 1'b1);
      reg_chk(OFS_RAW, p ? 32'h5 : 32'h1);
      reg_chk(OFS_MASKED, p ? 32'h4 : 32'h0);
      reg_wr(OFS_RAW, 32'h5);
    end
    reg_wr(OFS_CFG0 + 8'h04,
      asc_cfg_t'{1'b0, 1'b0, 4'h0, 6'h01, 3'h0, 4'h0, 6'h01, 3'h0, 2'h0, 2'h1});
    access(1'b0, 2'h1, 16'h0000);
    check(st, 2);
    reg_chk(OFS_EN_SET, 32'h4);
    reg_wr(OFS_EN_CLR, 32'h4);
    reg_chk(OFS_EN_SET, 32'h0);
    check(n_irq, 2);
    $display("test extended wait done");
    close_out();
  end
endmodule
